// ==== rtl/bafe_pkg.sv ====
/*
 * constants for the battery front end control and status register bank:
 * slave address, register offsets, field positions, reset values, timing.
 * assumes a 10 MHz system clock.
 */
package bafe_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int BAFE_CLK_HZ = 10_000_000;
	// watchdog gives up after this long without an input clock edge
	localparam int BAFE_WD_TIMEOUT_US = 500;
	localparam int BAFE_WD_TIMEOUT_CYC = BAFE_WD_TIMEOUT_US * (BAFE_CLK_HZ / 1_000_000);

	// ----------------------------------------
	// link and map
	// ----------------------------------------
	localparam logic [6:0] BAFE_SLAVE_ADDR = 7'h20;
	localparam logic [7:0] BAFE_OFS_STATUS = 8'h00;
	localparam logic [7:0] BAFE_OFS_OUT = 8'h01;
	localparam logic [7:0] BAFE_OFS_STATE = 8'h02;
	localparam logic [7:0] BAFE_OFS_FUNC = 8'h03;
	localparam logic [7:0] BAFE_OFS_CELL = 8'h04;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BAFE_ST_SCD = 0;
	localparam int BAFE_ST_SCC = 1;
	localparam int BAFE_ST_OL = 2;
	localparam int BAFE_ST_WDF = 3;
	localparam int BAFE_OC_REL = 0;
	localparam int BAFE_OC_DSG = 1;
	localparam int BAFE_OC_CHG = 2;
	localparam int BAFE_OC_ZVOFF = 3;
	localparam int BAFE_OC_OD = 4;
	localparam int BAFE_SC_SLEEP = 0;
	localparam int BAFE_SC_SHIP = 1;
	localparam int BAFE_SC_WATCHDOG_DISABLE = 2;
	localparam int BAFE_FC_VOLTAGE_MONITOR_ENABLE = 0;
	localparam int BAFE_FC_PACK = 1;
	localparam int BAFE_FC_XOL = 2;
	localparam int BAFE_FC_SHORT_CHARGE_SENSE_DISABLE = 3;
	localparam int BAFE_FC_SHORT_DISCHARGE_SENSE_DISABLE = 4;
	localparam int BAFE_FC_TPWR = 5;

	// ----------------------------------------
	// writable bits and reset values
	// ----------------------------------------
	localparam logic [7:0] BAFE_OC_MASK = 8'h1f;
	localparam logic [7:0] BAFE_SC_MASK = 8'h07;
	localparam logic [7:0] BAFE_FC_MASK = 8'h3f;
	localparam logic [7:0] BAFE_OC_RST = 8'h00;
	localparam logic [7:0] BAFE_SC_RST = 8'h00;
	localparam logic [7:0] BAFE_FC_RST = 8'h00;
	localparam logic [7:0] BAFE_CS_RST = 8'h00;

	typedef enum {
		S_IDLE, S_ADDR, S_AACK, S_REG, S_DACK, S_WDATA, S_RDATA, S_MACK
	} bafe_link_state_t;

endpackage

// ==== rtl/bafe_sync.sv ====
/*
 * two flip-flop synchroniser, one chain per bit.
 * assumes inputs are quasi-static against the sampling clock.
 */
`timescale 1ns/1ps
module bafe_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk_sys,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// ----------------------------------------
	// per-bit chains
	// ----------------------------------------
	// no reset: chains flush within the reset hold time
	for (genvar g = 0; g < WIDTH; g++) begin : g_bit
		logic meta_q;
		logic sync_q;
		always_ff @(posedge i_clk_sys) begin
			meta_q <= i_async[g];
			sync_q <= meta_q;
		end
		assign o_sync[g] = sync_q;
	end

endmodule

// ==== rtl/bafe_regs.sv ====
/*
 * control and status register bank of a multi-cell battery protection front
 * end, reached over an i2c compatible slave port; fault latches, watchdog
 * and output drive. assumes analog comparators and pins arrive asynchronous,
 * scl at most a few hundred khz against a 10 MHz system clock.
 */
// Overview of operation
// - status read releases the alert output
// - short-circuit flags per current direction
// - overload flag above threshold only
// - watchdog flag on stopped input clock
// - sleep flag mirrors sleep mode
// - clamp flag; top two bits zero
// - fault latches released by 0-1-0 write
// - discharge drive bit
// - charge drive bit, reset from strap
// - zero-volt drive bit active low
// - open-drain output pulled low when set
// - sleep control bit
// - ship mode once pack supply removed
// - watchdog disable bit
// - monitor enable, output grounded when off
// - pack voltage overrides cell selection
// - active high sense disables
// - thermistor supply control
// - monitored cell select
// - monitor calibration mode select
// - per-cell balance bypass enables
// - slave at address 0x20, clock input only
// - reads refused during sleep
// - register pointer never auto-increments
`timescale 1ns/1ps
module bafe_regs import bafe_pkg::*; #(
	parameter int WD_TIMEOUT_CYC = BAFE_WD_TIMEOUT_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_watchdog_clock_input,
	input wire logic i_sleep_pin,
	input wire logic i_pack_present,
	input wire logic i_precharge_mode_strap,
	input wire logic i_short_discharge_detect,
	input wire logic i_short_charge_detect,
	input wire logic i_overload_detect,
	input wire logic i_zero_volt_clamp,
	output logic o_alert_irq_n,
	output logic o_discharge_fet_on,
	output logic o_charge_fet_on,
	output logic o_zero_volt_fet_drive,
	output logic o_open_drain_output,
	output logic o_open_drain_output_oe,
	output logic o_ship_mode,
	output logic o_voltage_monitor_enable,
	output logic o_pack_voltage_select,
	output logic [1:0] o_monitor_cell_sel,
	output logic [1:0] o_monitor_mode,
	output logic [3:0] o_balance_enable,
	output logic o_thermistor_power_on
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (WD_TIMEOUT_CYC < 2 || WD_TIMEOUT_CYC > 65535) begin : g_bad_wd
		$error("watchdog count out of range");
	end
	localparam logic [15:0] WD_MAX = 16'(WD_TIMEOUT_CYC);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [9:0] pin_s;
	logic scl_s, sda_s, wdi_s, sleep_pin_s, pack_s, strap_s;
	logic scd_s, scc_s, ol_s, zvc_s;

	bafe_sync #(.WIDTH(10)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_async({i_scl, i_sda, i_watchdog_clock_input, i_sleep_pin, i_pack_present,
			i_precharge_mode_strap, i_short_discharge_detect, i_short_charge_detect,
			i_overload_detect, i_zero_volt_clamp}),
		.o_sync(pin_s)
	);
	assign {scl_s, sda_s, wdi_s, sleep_pin_s, pack_s, strap_s, scd_s, scc_s, ol_s, zvc_s} = pin_s;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	bafe_link_state_t state_q;
	logic scl_q, sda_q, wdi_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q, ptr_q, tx_q, rd_data, rd_status;
	logic rw_q, sda_oe_q, nack_q;
	logic [7:0] oc_q, sc_q, fc_q, cs_q;
	logic [3:0] fault_q, fault_set;
	logic [15:0] wd_cnt_q;
	logic alert_n_q;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic sleep_mode, addr_hit, load_rd, wr_stb, status_rd, lt_release, wd_to, fet_ok;

	// ----------------------------------------
	// link edges
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			wdi_q <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			wdi_q <= wdi_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det = scl_s & scl_q & ~sda_q & sda_s;
	assign sleep_mode = sleep_pin_s | sc_q[BAFE_SC_SLEEP];

	assign addr_hit = (shift_q[7:1] == BAFE_SLAVE_ADDR) && (!shift_q[0] || !sleep_mode);
	assign load_rd = scl_fall && ((state_q == S_AACK && rw_q) || (state_q == S_MACK && !nack_q));
	assign wr_stb = scl_fall && state_q == S_WDATA && cnt_q == 4'h8;
	assign status_rd = load_rd && ptr_q == BAFE_OFS_STATUS;

	// ----------------------------------------
	// slave protocol
	// ----------------------------------------
	// sda changes a few system clocks after scl falls, well inside the low phase
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			rw_q <= 1'b0;
			ptr_q <= 8'h00;
			tx_q <= 8'h00;
			sda_oe_q <= 1'b0;
			nack_q <= 1'b0;
		end else if (start_det) begin
			state_q <= S_ADDR;
			cnt_q <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (stop_det) begin
			state_q <= S_IDLE;
			sda_oe_q <= 1'b0;
		end else if (scl_rise) begin
			if (state_q == S_MACK) begin
				nack_q <= sda_s;
			end else if (state_q inside {S_ADDR, S_REG, S_WDATA, S_RDATA}) begin
				shift_q <= {shift_q[6:0], sda_s};
				cnt_q <= cnt_q + 4'h1;
			end
		end else if (scl_fall) begin
			unique case (state_q)
				S_IDLE: begin
					sda_oe_q <= 1'b0;
				end
				S_ADDR: begin
					if (cnt_q == 4'h8) begin
						if (addr_hit) begin
							state_q <= S_AACK;
							rw_q <= shift_q[0];
							sda_oe_q <= 1'b1;
						end else begin
							state_q <= S_IDLE;
						end
					end
				end
				S_AACK: begin
					cnt_q <= 4'h0;
					if (rw_q) begin
						state_q <= S_RDATA;
						tx_q <= {rd_data[6:0], 1'b0};
						sda_oe_q <= ~rd_data[7];
					end else begin
						state_q <= S_REG;
						sda_oe_q <= 1'b0;
					end
				end
				S_REG: begin
					// pointer set only by address byte
					if (cnt_q == 4'h8) begin
						ptr_q <= shift_q;
						state_q <= S_DACK;
						sda_oe_q <= 1'b1;
					end
				end
				S_WDATA: begin
					if (cnt_q == 4'h8) begin
						state_q <= S_DACK;
						sda_oe_q <= 1'b1;
					end
				end
				S_DACK: begin
					state_q <= S_WDATA;
					cnt_q <= 4'h0;
					sda_oe_q <= 1'b0;
				end
				S_RDATA: begin
					if (cnt_q == 4'h8) begin
						state_q <= S_MACK;
						sda_oe_q <= 1'b0;
					end else begin
						sda_oe_q <= ~tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
					end
				end
				S_MACK: begin
					if (!nack_q) begin
						state_q <= S_RDATA;
						cnt_q <= 4'h0;
						tx_q <= {rd_data[6:0], 1'b0};
						sda_oe_q <= ~rd_data[7];
					end else begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	// data pin only pulled low, clock never driven
	assign o_sda = 1'b0;
	assign o_sda_oe = sda_oe_q;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// status byte
	assign rd_status = {2'b00, zvc_s, sleep_mode, fault_q};

	always_comb begin
		unique case (ptr_q)
			BAFE_OFS_STATUS: rd_data = rd_status;
			BAFE_OFS_OUT: rd_data = oc_q;
			BAFE_OFS_STATE: rd_data = sc_q;
			BAFE_OFS_FUNC: rd_data = fc_q;
			BAFE_OFS_CELL: rd_data = cs_q;
			default: rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// strap is sampled while reset is held, so reset must span the chain
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			oc_q <= BAFE_OC_RST;
			oc_q[BAFE_OC_CHG] <= strap_s;
			sc_q <= BAFE_SC_RST;
			fc_q <= BAFE_FC_RST;
			cs_q <= BAFE_CS_RST;
		end else if (wr_stb) begin
			unique case (ptr_q)
				BAFE_OFS_OUT: oc_q <= shift_q & BAFE_OC_MASK;
				BAFE_OFS_STATE: sc_q <= shift_q & BAFE_SC_MASK;
				BAFE_OFS_FUNC: fc_q <= shift_q & BAFE_FC_MASK;
				BAFE_OFS_CELL: cs_q <= shift_q;
				default: ;
			endcase
		end
	end

	// release on the 1 to 0 step
	assign lt_release = wr_stb && ptr_q == BAFE_OFS_OUT && oc_q[BAFE_OC_REL] && !shift_q[BAFE_OC_REL];

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	// count since last input edge
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			wd_cnt_q <= 16'h0000;
		end else if (sc_q[BAFE_SC_WATCHDOG_DISABLE] || sleep_mode || (wdi_s ^ wdi_q)) begin
			wd_cnt_q <= 16'h0000;
		end else if (wd_cnt_q != WD_MAX) begin
			wd_cnt_q <= wd_cnt_q + 16'h0001;
		end
	end
	assign wd_to = wd_cnt_q == WD_MAX;

	// ----------------------------------------
	// fault latches and alert
	// ----------------------------------------
	// sense gated by disables
	assign fault_set[BAFE_ST_SCD] = scd_s & ~fc_q[BAFE_FC_SHORT_DISCHARGE_SENSE_DISABLE] & ~sleep_mode;
	assign fault_set[BAFE_ST_SCC] = scc_s & ~fc_q[BAFE_FC_SHORT_CHARGE_SENSE_DISABLE] & ~sleep_mode;
	assign fault_set[BAFE_ST_OL] = ol_s & ~fc_q[BAFE_FC_XOL] & ~sleep_mode;
	assign fault_set[BAFE_ST_WDF] = wd_to;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			fault_q <= 4'h0;
		end else if (lt_release) begin
			fault_q <= fault_set;
		end else begin
			fault_q <= fault_q | fault_set;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			alert_n_q <= 1'b1;
		end else if (|(fault_set & ~fault_q)) begin
			alert_n_q <= 1'b0;
		end else if (status_rd) begin
			alert_n_q <= 1'b1;
		end
	end
	assign o_alert_irq_n = alert_n_q;

	// ----------------------------------------
	// output drive
	// ----------------------------------------
	assign fet_ok = ~(|fault_q) & ~sleep_mode;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_discharge_fet_on <= 1'b0;
			o_charge_fet_on <= 1'b0;
			o_zero_volt_fet_drive <= 1'b0;
			o_open_drain_output <= 1'b0;
			o_open_drain_output_oe <= 1'b0;
			o_ship_mode <= 1'b0;
		end else begin
			// fets off on fault or sleep
			o_discharge_fet_on <= oc_q[BAFE_OC_DSG] & fet_ok;
			o_charge_fet_on <= oc_q[BAFE_OC_CHG] & fet_ok;
			o_zero_volt_fet_drive <= ~oc_q[BAFE_OC_ZVOFF] & fet_ok;
			o_open_drain_output <= 1'b0;
			o_open_drain_output_oe <= oc_q[BAFE_OC_OD];
			o_ship_mode <= sc_q[BAFE_SC_SHIP] & ~pack_s;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_voltage_monitor_enable <= 1'b0;
			o_pack_voltage_select <= 1'b0;
			o_monitor_cell_sel <= 2'h0;
			o_monitor_mode <= 2'h0;
			o_balance_enable <= 4'h0;
			o_thermistor_power_on <= 1'b0;
		end else begin
			o_voltage_monitor_enable <= fc_q[BAFE_FC_VOLTAGE_MONITOR_ENABLE] & ~sleep_mode;
			o_pack_voltage_select <= fc_q[BAFE_FC_VOLTAGE_MONITOR_ENABLE] & fc_q[BAFE_FC_PACK] & ~sleep_mode;
			o_monitor_cell_sel <= cs_q[1:0];
			o_monitor_mode <= cs_q[3:2];
			o_balance_enable <= sleep_mode ? 4'h0 : cs_q[7:4];
			o_thermistor_power_on <= fc_q[BAFE_FC_TPWR] & ~sleep_mode;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_alert_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		status_rd && !(|(fault_set & ~fault_q)) |=> o_alert_irq_n)
		else $error("alert not released by status read");

	a_alert_raise: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		|(fault_set & ~fault_q) |=> !o_alert_irq_n ##0 (|fault_q))
		else $error("new fault did not raise alert");

	a_status_top: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_status[7:6] == 2'h0 && rd_status[4] == sleep_mode)
		else $error("status upper bits wrong");

	a_wd_fault: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wd_to && !sc_q[BAFE_SC_WATCHDOG_DISABLE] && !sleep_mode |=> fault_q[BAFE_ST_WDF] [*2])
		else $error("watchdog timeout not latched");

	a_wd_disabled: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		sc_q[BAFE_SC_WATCHDOG_DISABLE] |=> wd_cnt_q == 16'h0000 && !wd_to)
		else $error("watchdog ran while disabled");

	a_latch_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(|fault_q) && !lt_release |=> (|fault_q))
		else $error("fault latch dropped without release");

	a_fet_fault: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(|fault_q) || sleep_mode |=> !o_discharge_fet_on && !o_charge_fet_on && !o_zero_volt_fet_drive)
		else $error("fet driven during fault or sleep");

	a_sleep_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		scl_fall && state_q == S_ADDR && cnt_q == 4'h8 && shift_q[0] && sleep_mode
		|=> state_q == S_IDLE && !o_sda_oe)
		else $error("read acknowledged in sleep");

	a_ptr_stable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q != S_REG |=> $stable(ptr_q))
		else $error("register pointer moved outside address byte");

	a_monitor_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!fc_q[BAFE_FC_VOLTAGE_MONITOR_ENABLE] |=> !o_voltage_monitor_enable && !o_pack_voltage_select)
		else $error("monitor active while disabled");

endmodule

// ==== test/bafe_host.sv ====
/*
 * host model on the i2c link: makes scl and pulls sda low.
 * assumes sda is resolved outside with a pull-up.
 */
`timescale 1ns/1ps
module bafe_host import bafe_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	// ----------------
	// bit level
	// ----------------
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	task automatic bit_io(input logic b, output logic r);
		cyc(2);
		o_sda_low <= !b;
		cyc(4);
		r = i_sda;
		o_scl <= 1'b1;
		cyc(2);
		o_scl <= 1'b0;
	endtask
	// three cycles first: device lets go of sda three cycles after a fall
	task automatic start();
		cyc(3);
		o_sda_low <= 1'b0;
		cyc(3);
		o_scl <= 1'b1;
		cyc(4);
		o_sda_low <= 1'b1;
		cyc(4);
		o_scl <= 1'b0;
	endtask
	task automatic stop();
		cyc(3);
		o_sda_low <= 1'b1;
		cyc(3);
		o_scl <= 1'b1;
		cyc(4);
		o_sda_low <= 1'b0;
		cyc(4);
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic [7:0] q;
		logic r;
		xfer(d, q);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// ----------------
	// transfers
	// ----------------
	// one pointer, two data bytes to it
	task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1, output logic ok);
		logic a0, a1, a2, a3;
		start();
		send({BAFE_SLAVE_ADDR, 1'b0}, a0);
		send(p, a1);
		send(d0, a2);
		send(d1, a3);
		stop();
		ok = a0 & a1 & a2 & a3;
	endtask
	// without setp the last pointer is read again
	task automatic rd(input logic [7:0] p, input logic setp, output logic [7:0] q0, output logic [7:0] q1,
			output logic ok);
		logic a;
		logic r;
		if (setp) begin
			start();
			send({BAFE_SLAVE_ADDR, 1'b0}, a);
			send(p, a);
		end
		start();
		send({BAFE_SLAVE_ADDR, 1'b1}, ok);
		if (ok) begin
			xfer(8'hff, q0);
			bit_io(1'b0, r);
			xfer(8'hff, q1);
			bit_io(1'b1, r);
		end
		stop();
	endtask
endmodule

// ==== test/tb.sv ====
/*
 * self-checking bench for the register bank: host model on the link,
 * integer model of registers and fault latches. assumes a 10 MHz clock.
 */
`timescale 1ns/1ps
module tb import bafe_pkg::*;;
	logic i_clk_sys, i_rst, scl, host_low, sda_oe, od, watchdog_clock_input, wd_run, slp_pin, pack, strap, clamp, alert_n;
	logic discharge_fet_on, charge_fet_on, zv, od_oe, ship, vm, pk, therm, slp;
	logic [1:0] csel, mode;
	logic [3:0] bal;
	logic [2:0] det;
	logic [7:0] v, q0, q1;
	logic ok, sdo;
	int oc, sc, fc, cs, flt, wd_cnt, n_mismatch, checks_done;
	// the device only pulls low when its enable is up and its data is 0
	wire sda = !(host_low || (sda_oe && !sdo));

	// ----------------
	// instances
	// ----------------
	bafe_regs #(.WD_TIMEOUT_CYC(400)) i_bafe_regs (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(scl),
		.i_sda(sda), .o_sda(sdo), .o_sda_oe(sda_oe), .i_watchdog_clock_input(watchdog_clock_input), .i_sleep_pin(slp_pin),
		.i_pack_present(pack), .i_precharge_mode_strap(strap), .i_short_discharge_detect(det[0]),
		.i_short_charge_detect(det[1]), .i_overload_detect(det[2]), .i_zero_volt_clamp(clamp),
		.o_alert_irq_n(alert_n), .o_discharge_fet_on(discharge_fet_on), .o_charge_fet_on(charge_fet_on), .o_zero_volt_fet_drive(zv),
		.o_open_drain_output(od), .o_open_drain_output_oe(od_oe), .o_ship_mode(ship),
		.o_voltage_monitor_enable(vm), .o_pack_voltage_select(pk), .o_monitor_cell_sel(csel),
		.o_monitor_mode(mode), .o_balance_enable(bal), .o_thermistor_power_on(therm));
	bafe_host i_bafe_host (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = !i_clk_sys;
	end
	// 156-cycle half period, about 32 kHz
	always @(posedge i_clk_sys) begin
		if (wd_run) begin
			wd_cnt <= (wd_cnt == 155) ? 0 : wd_cnt + 1;
			if (wd_cnt == 155) watchdog_clock_input <= !watchdog_clock_input;
		end
	end

	// ----------------
	// model and checks
	// ----------------
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		checks_done++;
		if (got !== e) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, e);
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [7:0] p);
		case (p)
			8'h00: return {2'h0, clamp, 1'b0, 4'(flt)};
			8'h01: return 8'(oc);
			8'h02: return 8'(sc);
			8'h03: return 8'(fc);
			8'h04: return 8'(cs);
			default: return 8'h00;
		endcase
	endfunction
	task automatic put(input logic [7:0] p, input logic [7:0] d);
		case (p)
			8'h01: begin
				if (oc[0] && !d[0]) flt = 0;
				oc = d & 8'h1f;
			end
			8'h02: sc = d & 8'h07;
			8'h03: fc = d & 8'h3f;
			8'h04: cs = d;
			default: ;
		endcase
		slp = sc[0] || slp_pin;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
		i_bafe_host.wr(p, d0, d1, ok);
		chk(ok, 1'b1);
		put(p, d0);
		put(p, d1);
	endtask
	task automatic rd_chk(input logic [7:0] p, input logic setp, input logic ok_e);
		i_bafe_host.rd(p, setp, q0, q1, ok);
		chk(ok, ok_e);
		if (ok_e) chk({q0, q1}, {exp_rd(p), exp_rd(p)});
	endtask
	task automatic chk_outs();
		logic en;
		logic [16:0] e;
		en = (flt == 0) && !slp;
		// pack select only counts while monitoring is enabled
		e = {1'b0, en & oc[1], en & oc[2], en & !oc[3], oc[4], sc[1] & !pack, !slp & fc[0],
			!slp & fc[0] & fc[1], cs[1:0], cs[3:2], slp ? 4'h0 : cs[7:4], !slp & fc[5]};
		chk({od, discharge_fet_on, charge_fet_on, zv, od_oe, ship, vm, pk, csel, mode, bal, therm}, e);
	endtask
	task automatic do_reset();
		i_rst <= 1'b1;
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
		oc = strap ? 4 : 0;
		sc = 0;
		fc = 0;
		cs = 0;
		flt = 0;
		slp = slp_pin;
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask

	// ----------------
	// sequence
	// ----------------
	initial begin
		i_rst = 1'b1;
		wd_run = 1'b1;
		watchdog_clock_input = 1'b0;
		wd_cnt = 0;
		slp_pin = 1'b0;
		pack = 1'b1;
		strap = 1'b0;
		clamp = 1'b0;
		det = 3'h0;
		void'($urandom(18997));
		do_reset();
		chk(alert_n, 1'b1);
		chk_outs();
		for (int r = 0; r <= 5; r++) rd_chk(8'(r), 1'b1, 1'b1);
		$display("test reset done");
		for (int r = 1; r <= 5; r++) begin
			repeat (3) begin
				v = 8'($urandom);
				if (r == 2) v[0] = 1'b0;
				pack <= v[7];
				wr(8'(r), v ^ 8'h5a, v);
				chk_outs();
				rd_chk(8'(r), 1'b1, 1'b1);
				rd_chk(8'(r), 1'b0, 1'b1);
			end
		end
		$display("test registers done");
		pack <= 1'b1;
		wr(8'h02, 8'h00, 8'h00);
		wr(8'h01, 8'h00, 8'h06);
		for (int i = 0; i < 3; i++) begin
			for (int dis = 1; dis >= 0; dis--) begin
				v = 8'h00;
				v[4 - i] = dis[0];
				wr(8'h03, 8'h00, v);
				det[i] <= 1'b1;
				hold(10);
				det[i] <= 1'b0;
				hold(10);
				if (dis == 0) flt = 1 << i;
				chk(alert_n, flt == 0);
				chk_outs();
				rd_chk(8'h00, 1'b1, 1'b1);
				chk(alert_n, 1'b1);
				wr(8'h01, 8'(oc | 1), 8'(oc & 8'hfe));
				// the release write moved the pointer, so set it back to status
				rd_chk(8'h00, 1'b1, 1'b1);
				chk_outs();
			end
		end
		$display("test faults done");
		wd_run <= 1'b0;
		hold(600);
		flt = 8;
		chk_outs();
		rd_chk(8'h00, 1'b1, 1'b1);
		wd_run <= 1'b1;
		hold(400);
		wr(8'h01, 8'(oc | 1), 8'(oc & 8'hfe));
		rd_chk(8'h00, 1'b1, 1'b1);
		// fets off, then the watchdog disabled before its input clock stops
		wr(8'h01, 8'h00, 8'h00);
		wr(8'h02, 8'h00, 8'h04);
		wd_run <= 1'b0;
		hold(600);
		rd_chk(8'h00, 1'b1, 1'b1);
		wd_run <= 1'b1;
		hold(400);
		wr(8'h02, 8'h00, 8'h00);
		wr(8'h01, 8'h00, 8'h06);
		$display("test watchdog done");
		wr(8'h03, 8'h00, 8'h21);
		wr(8'h02, 8'h00, 8'h01);
		chk_outs();
		rd_chk(8'h00, 1'b1, 1'b0);
		wr(8'h04, 8'h00, 8'ha5);
		wr(8'h02, 8'h00, 8'h00);
		chk_outs();
		rd_chk(8'h04, 1'b1, 1'b1);
		slp_pin <= 1'b1;
		hold(10);
		slp = 1'b1;
		chk_outs();
		rd_chk(8'h04, 1'b1, 1'b0);
		slp_pin <= 1'b0;
		hold(10);
		slp = 1'b0;
		clamp <= 1'b1;
		hold(10);
		rd_chk(8'h00, 1'b1, 1'b1);
		clamp <= 1'b0;
		$display("test sleep and clamp done");
		strap <= 1'b1;
		do_reset();
		chk_outs();
		rd_chk(8'h01, 1'b1, 1'b1);
		$display("test strap done");
		end_sim();
	end
	initial begin
		hold(90000);
		n_mismatch++;
		end_sim();
	end
endmodule
